// file: shared/dpsc_pkg.sv
// constants and carrier types for the dual pot serial control block
package dpsc_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int NV_WRITE_TIME_US = 5000;
    localparam int NV_WRITE_CYCLES = NV_WRITE_TIME_US * CLK_MHZ;

    // ------------------------------------------------------------
    // instruction byte: opcode [7:4], device address [3:2]
    // ------------------------------------------------------------
    localparam int INSTR_OP_LSB = 4;
    localparam int INSTR_ADDR_LSB = 2;
    localparam logic [3:0] OP_RD_WIPER = 4'h9;
    localparam logic [3:0] OP_WR_WIPER = 4'hA;
    localparam logic [3:0] OP_RD_NV = 4'hB;
    localparam logic [3:0] OP_WR_NV = 4'hC;
    localparam logic [3:0] OP_XFER = 4'hD;
    localparam logic [3:0] OP_INCDEC = 4'h2;

    // ------------------------------------------------------------
    // address byte: pot [7], slot [6:5], copy direction [4]
    // ------------------------------------------------------------
    localparam int AB_POT_BIT = 7;
    localparam int AB_SLOT_LSB = 5;
    localparam int AB_DIR_BIT = 4;

    // ------------------------------------------------------------
    // bit counts and reset values
    // ------------------------------------------------------------
    localparam logic [4:0] LAST_INSTR_BIT = 5'h07;
    localparam logic [4:0] LAST_ADDR_BIT = 5'h0F;
    localparam logic [4:0] LAST_DATA_BIT = 5'h17;
    localparam logic [7:0] NV_RESET_VAL = 8'h80;
    localparam logic [7:0] WIPER_RESET_VAL = 8'h80;
    localparam logic [7:0] WIPER_MAX = 8'hFF;
    localparam logic [7:0] WIPER_MIN = 8'h00;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_INSTR,
        ST_ADDR,
        ST_DATA,
        ST_INCDEC,
        ST_DONE
    } dpsc_state_t;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic write_protect_n;
        logic pause_n;
        logic select_addr_msb;
        logic select_addr_lsb;
    } dpsc_pins_t;

    typedef struct packed {
        logic [7:0] pot1;
        logic [7:0] pot0;
    } dpsc_wipers_t;
endpackage

// file: hw/dpsc_top.sv
// serial control logic for a dual 256-tap digital potentiometer
`timescale 1ns/1ps
module dpsc_top
    import dpsc_pkg::*;
#(
    parameter int NV_WRITE_CYCLES_P = dpsc_pkg::NV_WRITE_CYCLES
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire dpsc_pkg::dpsc_pins_t pins_i,
    output logic so_o,
    output logic so_oe_o,
    output dpsc_pkg::dpsc_wipers_t wipers_o,
    output logic [255:0] tap0_o,
    output logic [255:0] tap1_o,
    output logic nv_busy_o,
    output logic standby_o
);
    import dpsc_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------------------
    dpsc_pins_t sync1;
    dpsc_pins_t s;
    dpsc_pins_t prev;

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1 <= '{cs_n: 1'b1, pause_n: 1'b1, write_protect_n: 1'b1, default: 1'b0};
            s <= '{cs_n: 1'b1, pause_n: 1'b1, write_protect_n: 1'b1, default: 1'b0};
            prev <= '{cs_n: 1'b1, pause_n: 1'b1, write_protect_n: 1'b1, default: 1'b0};
        end else begin
            sync1 <= pins_i;
            s <= sync1;
            prev <= s;
        end
    end

    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;
    logic wp_fall;
    assign sck_rise = s.sck & ~prev.sck;
    assign sck_fall = ~s.sck & prev.sck;
    assign cs_fall = ~s.cs_n & prev.cs_n;
    assign cs_rise = s.cs_n & ~prev.cs_n;
    assign wp_fall = ~s.write_protect_n & prev.write_protect_n;

    // ------------------------------------------------------------
    // pause
    // ------------------------------------------------------------
    logic paused;
    logic active;

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            paused <= 1'b0;
        end else if (s.cs_n) begin
            paused <= 1'b0;
        end else if (!s.sck) begin
            paused <= ~s.pause_n;
        end
    end

    assign active = ~s.cs_n & ~paused;

    // ------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------
    dpsc_state_t state;
    logic [4:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] instr;
    logic [7:0] abyte;
    logic [7:0] rd_sh;
    logic [7:0] wiper [2];
    logic [7:0] nv [8];
    logic nv_pend;
    logic [2:0] nv_pend_idx;
    logic [7:0] nv_pend_data;
    logic wp_abort;
    logic boot;
    logic so_bit;
    logic [7:0] nb;
    logic [3:0] op;
    logic [2:0] idx;
    logic pot;
    logic addr_ok;
    logic op_ok;
    logic reading;

    assign nb = {shreg[6:0], s.si};
    assign op = instr[INSTR_OP_LSB +: 4];
    assign pot = abyte[AB_POT_BIT];
    assign idx = {abyte[AB_POT_BIT], abyte[AB_SLOT_LSB +: 2]};
    assign addr_ok = nb[INSTR_ADDR_LSB +: 2] == {s.select_addr_msb, s.select_addr_lsb};
    assign op_ok = nb[INSTR_OP_LSB +: 4] inside {OP_RD_WIPER, OP_WR_WIPER, OP_RD_NV,
                                                 OP_WR_NV, OP_XFER, OP_INCDEC};
    assign reading = (state == ST_DATA) & ((op == OP_RD_WIPER) | (op == OP_RD_NV));

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wp_abort <= 1'b0;
        end else if (wp_fall && !s.cs_n) begin
            wp_abort <= 1'b1;
        end else if (cs_fall) begin
            wp_abort <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= ST_IDLE;
            bit_cnt <= 5'h00;
            shreg <= 8'h00;
            instr <= 8'h00;
            abyte <= 8'h00;
            rd_sh <= 8'h00;
            so_bit <= 1'b0;
            wiper[0] <= WIPER_RESET_VAL;
            wiper[1] <= WIPER_RESET_VAL;
            nv_pend <= 1'b0;
            nv_pend_idx <= 3'h0;
            nv_pend_data <= 8'h00;
            boot <= 1'b1;
        end else if (boot) begin
            wiper[0] <= nv[0];
            wiper[1] <= nv[4];
            boot <= 1'b0;
        end else if (cs_fall) begin
            state <= ST_INSTR;
            bit_cnt <= 5'h00;
            nv_pend <= 1'b0;
        end else if (s.cs_n) begin
            state <= ST_IDLE;
            nv_pend <= nv_pend & cs_rise;
        end else begin
            if (active && sck_fall && reading) begin
                so_bit <= rd_sh[7];
                rd_sh <= {rd_sh[6:0], 1'b0};
            end
            if (active && sck_rise) begin
                shreg <= nb;
                bit_cnt <= bit_cnt + 5'h01;
                case (state)
                    ST_INSTR: begin
                        if (bit_cnt == LAST_INSTR_BIT) begin
                            instr <= nb;
                            state <= (addr_ok && op_ok) ? ST_ADDR : ST_DONE;
                        end
                    end
                    ST_ADDR: begin
                        if (bit_cnt == LAST_ADDR_BIT) begin
                            abyte <= nb;
                            state <= ST_DATA;
                            case (op)
                                OP_RD_WIPER: begin
                                    rd_sh <= wiper[nb[AB_POT_BIT]];
                                end
                                OP_RD_NV: begin
                                    rd_sh <= nv[{nb[AB_POT_BIT], nb[AB_SLOT_LSB +: 2]}];
                                end
                                OP_XFER: begin
                                    state <= ST_DONE;
                                    if (nb[AB_DIR_BIT]) begin
                                        nv_pend <= 1'b1;
                                        nv_pend_idx <= {nb[AB_POT_BIT], nb[AB_SLOT_LSB +: 2]};
                                        nv_pend_data <= wiper[nb[AB_POT_BIT]];
                                    end else begin
                                        wiper[nb[AB_POT_BIT]] <=
                                            nv[{nb[AB_POT_BIT], nb[AB_SLOT_LSB +: 2]}];
                                    end
                                end
                                OP_INCDEC: begin
                                    state <= ST_INCDEC;
                                end
                                default: begin
                                end
                            endcase
                        end
                    end
                    ST_DATA: begin
                        if (bit_cnt == LAST_DATA_BIT) begin
                            state <= ST_DONE;
                            if (op == OP_WR_WIPER) begin
                                wiper[pot] <= nb;
                            end
                            if (op == OP_WR_NV) begin
                                nv_pend <= 1'b1;
                                nv_pend_idx <= idx;
                                nv_pend_data <= nb;
                            end
                        end
                    end
                    ST_INCDEC: begin
                        if (s.si && wiper[pot] != WIPER_MAX) begin
                            wiper[pot] <= wiper[pot] + 8'h01;
                        end else if (!s.si && wiper[pot] != WIPER_MIN) begin
                            wiper[pot] <= wiper[pot] - 8'h01;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // non-volatile write engine
    // ------------------------------------------------------------
    logic nv_busy;
    logic [31:0] nv_timer;
    logic [2:0] nv_idx;
    logic [7:0] nv_data;
    logic nv_start;

    assign nv_start = cs_rise & nv_pend & ~wp_abort & s.write_protect_n
                      & ~nv_busy;

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            nv_busy <= 1'b0;
            nv_timer <= 32'h0000_0000;
            nv_idx <= 3'h0;
            nv_data <= 8'h00;
            for (int i = 0; i < 8; i++) begin
                nv[i] <= NV_RESET_VAL;
            end
        end else if (nv_start) begin
            nv_busy <= 1'b1;
            nv_timer <= 32'h0000_0000;
            nv_idx <= nv_pend_idx;
            nv_data <= nv_pend_data;
        end else if (nv_busy) begin
            if (nv_timer == 32'(NV_WRITE_CYCLES_P - 1)) begin
                nv_busy <= 1'b0;
                nv[nv_idx] <= nv_data;
            end else begin
                nv_timer <= nv_timer + 32'h0000_0001;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic [255:0] tap_sel [2];

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tap_sel <= '{default: 256'h0};
        end else begin
            for (int g = 0; g < 2; g++) begin
                tap_sel[g] <= 256'h1 << wiper[g];
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wipers_o <= '0;
        end else begin
            wipers_o <= '{pot1: wiper[1], pot0: wiper[0]};
        end
    end

    assign tap0_o = tap_sel[0];
    assign tap1_o = tap_sel[1];

    assign so_o = so_bit;
    assign so_oe_o = active & reading;
    assign nv_busy_o = nv_busy;
    assign standby_o = s.cs_n & ~nv_busy;
endmodule

// file: testbench/dpsc_top_assertions.sv
// concurrent checks on the pot control ports
`timescale 1ns/1ps
module dpsc_top_assertions #(
    parameter int NV_WRITE_CYCLES_P = 20
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire dpsc_pkg::dpsc_pins_t pins_i,
    input wire logic so_o,
    input wire logic so_oe_o,
    input wire dpsc_pkg::dpsc_wipers_t wipers_o,
    input wire logic [255:0] tap0_o,
    input wire logic [255:0] tap1_o,
    input wire logic nv_busy_o,
    input wire logic standby_o
);
    import dpsc_pkg::*;
    int busy_len;
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_len <= 0;
        end else begin
            busy_len <= nv_busy_o ? busy_len + 1 : 0;
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_deselected;
        pins_i.cs_n [*5];
    endsequence
    sequence s_held;
        (!pins_i.pause_n && !pins_i.sck) [*5];
    endsequence
    a_so_float: assert property (pins_i.cs_n [*3] |-> !so_oe_o)
        else $error("so driven while deselected");
    a_standby_busy: assert property (nv_busy_o |-> !standby_o)
        else $error("standby during nv write");
    a_idle_wipers: assert property (s_deselected ##0 $past(rst_b_i, 5) |-> $stable(wipers_o))
        else $error("wiper moved while deselected");
    a_tap0_onehot: assert property ($past(rst_b_i, 3) |-> tap0_o == (256'h1 << wipers_o.pot0))
        else $error("pot0 tap mismatch");
    a_tap1_onehot: assert property ($past(rst_b_i, 3) |-> tap1_o == (256'h1 << wipers_o.pot1))
        else $error("pot1 tap mismatch");
    a_busy_len: assert property ($fell(nv_busy_o) |-> busy_len == NV_WRITE_CYCLES_P)
        else $error("nv write length wrong");
    a_busy_start: assert property ($rose(nv_busy_o) |->
        $past(pins_i.cs_n, 2) && $past(pins_i.write_protect_n, 2))
        else $error("nv write started wrongly");
    a_pause_float: assert property (s_held |-> !so_oe_o)
        else $error("so driven while paused");
    a_so_on_fall: assert property ($past(so_oe_o) && so_oe_o && $changed(so_o) |->
        $past(pins_i.sck, 4) && !pins_i.sck)
        else $error("so changed off a falling sck");
endmodule
bind dpsc_top dpsc_top_assertions #(.NV_WRITE_CYCLES_P(NV_WRITE_CYCLES_P)) u_chk (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .pins_i(pins_i), .so_o(so_o), .so_oe_o(so_oe_o),
    .wipers_o(wipers_o), .tap0_o(tap0_o), .tap1_o(tap1_o), .nv_busy_o(nv_busy_o),
    .standby_o(standby_o));

// file: testbench/dpsc_master.sv
// spi master model driving the pot control pins
`timescale 1ns/1ps
module dpsc_master (
    input wire logic so_i,
    input wire logic so_oe_i,
    output dpsc_pkg::dpsc_pins_t pins_o
);
    import dpsc_pkg::*;
    initial pins_o = 7'h5C;
    task automatic xfer(input logic [23:0] d, input int n, pz, wz, output logic [7:0] rd);
        rd = 8'h00;
        pins_o.cs_n = 1'b0;
        #300;
        for (int i = 0; i < n; i++) begin
            if (i == pz) begin
                pins_o.pause_n = 1'b0;
                repeat (8) #60 {pins_o.sck, pins_o.si} = ~{pins_o.sck, pins_o.si};
                #40 pins_o.pause_n = 1'b1;
                #100;
            end
            if (i == wz) pins_o.write_protect_n = 1'b0;
            if (wz >= 0 && i == wz + 2) pins_o.write_protect_n = 1'b1;
            pins_o.si = d[23 - i];
            #62.5 pins_o.sck = 1'b1;
            if (so_oe_i) rd = {rd[6:0], so_i};
            #62.5 pins_o.sck = 1'b0;
        end
        #300 pins_o.cs_n = 1'b1;
        pins_o.si = ~pins_o.si;
        if (wz == 99) begin
            #100 pins_o.write_protect_n = 1'b0;
            #100 pins_o.write_protect_n = 1'b1;
        end
        #400;
    endtask
    task automatic set_strap(input logic lsb, input logic wp);
        pins_o.select_addr_lsb = lsb;
        pins_o.write_protect_n = wp;
    endtask
endmodule

// file: testbench/dual_pot_serial_control_tb.sv
// self-checking bench for the pot control block
`timescale 1ns/1ps
module dual_pot_serial_control_tb;
    import dpsc_pkg::*;
    logic mclk_i, rst_b_i, so_o, so_oe_o, nv_busy_o, standby_o;
    dpsc_pins_t pins;
    dpsc_wipers_t wipers_o;
    logic [255:0] tap0_o, tap1_o;
    logic [31:0] lf = 32'h00017385;
    int bad_count, checks;
    int nv[8];
    int w[2];
    dpsc_top #(.NV_WRITE_CYCLES_P(20)) dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .pins_i(pins),
        .so_o(so_o), .so_oe_o(so_oe_o), .wipers_o(wipers_o), .tap0_o(tap0_o),
        .tap1_o(tap1_o), .nv_busy_o(nv_busy_o), .standby_o(standby_o));
    dpsc_master m (.so_i(so_o), .so_oe_i(so_oe_o), .pins_o(pins));
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task check(input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value t=%0t seen %h expected %h", $time, s, e);
        end
    endtask
    task stop_test;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic run(input logic [23:0] d, input int n, pz = -1, wz = -1);
        logic [7:0] rd;
        int p, s, g;
        m.xfer(d, n, pz, wz, rd);
        p = d[15];
        s = p * 4 + d[14:13];
        g = pins.write_protect_n && (wz < 0 || wz == 99);
        if (d[19:18] == {pins.select_addr_msb, pins.select_addr_lsb}) case (d[23:20])
            OP_WR_WIPER: if (n >= 24) w[p] = d[7:0];
            OP_WR_NV: if (n >= 24 && g) nv[s] = d[7:0];
            OP_XFER: if (!d[12]) w[p] = nv[s]; else if (g) nv[s] = w[p];
            OP_INCDEC: for (int i = 16; i < n; i++) begin
                if (d[23 - i]) w[p] = w[p] < 255 ? w[p] + 1 : 255;
                else w[p] = w[p] > 0 ? w[p] - 1 : 0;
            end
            OP_RD_WIPER: check(16'(rd), 16'(w[p]));
            OP_RD_NV: check(16'(rd), 16'(nv[s]));
            default: ;
        endcase
        for (int k = 0; k < 200 && nv_busy_o; k++) @(negedge mclk_i);
        @(negedge mclk_i);
        check(wipers_o, {w[1][7:0], w[0][7:0]});
        check(16'(standby_o), 16'h0001);
        check(16'(tap0_o[w[0][7:0]] & tap1_o[w[1][7:0]]), 16'h0001);
    endtask
    initial begin
        #600000;
        bad_count++;
        stop_test();
    end
    initial begin
        rst_b_i = 1'b0;
        for (int i = 0; i < 8; i++) nv[i] = int'(NV_RESET_VAL);
        w = '{nv[0], nv[4]};
        repeat (20) @(negedge mclk_i);
        rst_b_i = 1'b1;
        repeat (10) @(negedge mclk_i);
        check(wipers_o, {nv[4][7:0], nv[0][7:0]});
        for (int i = 0; i < 8; i++) begin
            lf = nx(lf);
            run({OP_WR_NV, 4'h0, i[2:0], 5'h00, lf[7:0]}, 24);
            run({OP_RD_NV, 4'h0, i[2:0], 13'h0000}, 24);
            run({OP_WR_WIPER, 4'h0, i[2:0], 5'h00, lf[15:8]}, 24);
            run({OP_RD_WIPER, 4'h0, i[2:0], 13'h0000}, 24);
            run({OP_XFER, 4'h0, i[2:0], 1'b0, 12'h000}, 16);
            run({OP_WR_WIPER, 4'h0, i[2:0], 5'h00, lf[23:16]}, 24);
            run({OP_XFER, 4'h0, i[2:0], 1'b1, 12'h000}, 16);
            run({OP_RD_NV, 4'h0, i[2:0], 13'h0000}, 24);
        end
        for (int op = 0; op < 16; op++) run({op[3:0], 4'h0, 8'h00, 8'h33}, 24);
        @(negedge mclk_i) m.set_strap(1'b1, 1'b1);
        run({OP_WR_WIPER, 4'h0, 8'h00, 8'h5A}, 24);
        run({OP_WR_WIPER, 4'h4, 8'h80, 8'h5A}, 24);
        @(negedge mclk_i) m.set_strap(1'b0, 1'b0);
        run({OP_WR_NV, 4'h0, 8'h20, 8'hC3}, 24);
        run({OP_WR_WIPER, 4'h0, 8'h20, 8'hC3}, 24);
        run({OP_RD_NV, 4'h0, 8'h20, 8'h00}, 24);
        @(negedge mclk_i) m.set_strap(1'b0, 1'b1);
        run({OP_WR_NV, 4'h0, 8'h20, 8'h3C}, 24, -1, 10);
        run({OP_WR_NV, 4'h0, 8'h20, 8'h3C}, 20);
        run({OP_RD_NV, 4'h0, 8'h20, 8'h00}, 24);
        run({OP_WR_NV, 4'h0, 8'h20, 8'h3C}, 24, -1, 99);
        run({OP_RD_NV, 4'h0, 8'h20, 8'h00}, 24);
        run({OP_WR_WIPER, 4'h0, 8'h80, 8'h96}, 24, 9);
        run({OP_RD_WIPER, 4'h0, 8'h80, 8'h00}, 24, 18);
        run({OP_WR_WIPER, 4'h0, 8'h00, 8'hFD}, 24);
        run({OP_INCDEC, 4'h0, 8'h00, 8'hE0}, 24);
        run({OP_WR_WIPER, 4'h0, 8'h80, 8'h03}, 24);
        run({OP_INCDEC, 4'h0, 8'h80, 8'h01}, 24);
        stop_test();
    end
endmodule
